/* File: hdl/sacr_pkg.sv */
// constants, state types and rule summary for the converter control and readout block
// Overview of operation
// - sync mode: select and strobe low start
// - async mode: strobe fall starts, select ignored
// - conversion triggers on strobe falling edge
// - host avoids select-after-strobe start ordering
// - idle: done high, sampler tracking
// - start: sampler holds, done goes low
// - mid-conversion track again; done high at end
// - host may switch channel when done falls
// - strobes at least 5 us apart
// - async: done pin open drain when enabled
// - sync: done pin driven when selected, enabled
// - result bus driven only select and read low
// - host reads after done, select before read
// - wide mode: twelve bits in one read
// - byte mode: low two lines are format inputs
// - byte mode: upper eight lines, high byte first
// - byte justification and fill bits
// - unipolar result is straight binary
// - bipolar result is twos complement
// - about 10 us internal reset after power-up
// - static bus-width select chooses format
package sacr_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RES_W = 12;
   // device timing, least times rounded up to whole cycles
   localparam int POWER_UP_NS = 10000;
   localparam int HOLD_TIME_NS = 1000;
   localparam int CONV_TIME_NS = 4000;
   localparam int POWER_UP_CYC = (POWER_UP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host timing
   localparam int START_PULSE_MIN_NS = 50;
   localparam int SELECT_TO_START_SETUP_NS = 20;
   localparam int SELECT_TO_READ_SETUP_NS = 20;
   localparam int READ_TO_START_RECOVERY_NS = 100;
   localparam int START_REPEAT_INTERVAL_NS = 5000;
   localparam int START_PULSE_MIN_CYC =
      (START_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_TO_START_SETUP_CYC =
      (SELECT_TO_START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_TO_READ_SETUP_CYC =
      (SELECT_TO_READ_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_TO_START_RECOVERY_CYC =
      (READ_TO_START_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_REPEAT_INTERVAL_CYC =
      (START_REPEAT_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_CYC = 2;
   // host register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CMD = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'hc;
   // control register fields and reset value
   localparam int CTRL_SYNC_BIT = 0;
   localparam int CTRL_WIDE_BIT = 1;
   localparam int CTRL_BIPOLAR_BIT = 2;
   localparam int CTRL_RIGHT_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h3;
   // command and status fields
   localparam int CMD_START_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_VALID_BIT = 2;
   typedef enum logic [3:0] {
      D_PWRUP = 4'h1,
      D_IDLE = 4'h2,
      D_HOLD = 4'h4,
      D_TRACK = 4'h8
   } sacr_dev_state_e;
   typedef enum logic [7:0] {
      H_IDLE = 8'h01,
      H_SETUP = 8'h02,
      H_STROBE = 8'h04,
      H_WAIT = 8'h08,
      H_RDSETUP = 8'h10,
      H_RDHI = 8'h20,
      H_RDLO = 8'h40,
      H_RECOVER = 8'h80
   } sacr_host_state_e;
endpackage

/* File: hdl/sacr_link_if.sv */
// pin-level link between the converter and its bus host, with wire resolution
`timescale 1ns/1ps
interface sacr_link_if;
   logic start_strobe_n;
   logic chip_select_n;
   logic read_enable_n;
   logic done_flag_enable_n;
   logic sync_mode;
   logic wide_mode;
   logic offset_range_pin;
   logic done_out;
   logic done_oe;
   logic done_pin;
   logic [11:0] dev_bus_out;
   logic [11:0] dev_bus_oe;
   logic [1:0] host_bus_out;
   logic [1:0] host_bus_oe;
   logic [11:0] result_bus;
   // pull-ups hold undriven lines high
   assign done_pin = done_oe ? done_out : 1'b1;
   assign result_bus[11:2] = dev_bus_out[11:2] | ~dev_bus_oe[11:2];
   for (genvar i = 0; i < 2; i++) begin : g_low
      assign result_bus[i] = dev_bus_oe[i] ? dev_bus_out[i] :
                             (host_bus_oe[i] ? host_bus_out[i] : 1'b1);
   end
   modport device (
      input start_strobe_n, chip_select_n, read_enable_n, done_flag_enable_n,
      input sync_mode, wide_mode, offset_range_pin, result_bus,
      output done_out, done_oe, dev_bus_out, dev_bus_oe
   );
   modport host (
      output start_strobe_n, chip_select_n, read_enable_n, done_flag_enable_n,
      output sync_mode, wide_mode, offset_range_pin, host_bus_out, host_bus_oe,
      input done_pin, result_bus
   );
endinterface

/* File: hdl/sacr_device.sv */
// converter end: start detection, conversion sequencing, done pin and result bus
`timescale 1ns/1ps
module sacr_device #(
   parameter int PWRUP_CYC = sacr_pkg::POWER_UP_CYC,
   parameter int HOLD_CYC = sacr_pkg::HOLD_CYC,
   parameter int CONV_CYC = sacr_pkg::CONV_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   sacr_link_if.device link,
   input wire logic [11:0] sample_level_i,
   output logic track_o,
   output logic converting_o
);
   sacr_pkg::sacr_dev_state_e state_q;
   logic [15:0] cnt_q;
   logic sc_q;
   logic cs_q;
   logic start_cond;
   logic [11:0] held_q;
   logic [11:0] result_q;
   logic [11:0] code;
   logic [7:0] byte_sel;
   logic [11:0] bus_q;
   logic [11:0] bus_oe_q;

   // previous pin levels for falling-edge detection
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         sc_q <= 1'b1;
         cs_q <= 1'b1;
      end else if (ce_i) begin
         sc_q <= link.start_strobe_n;
         cs_q <= link.chip_select_n;
      end
   end

   // start when the gating condition first becomes true
   always_comb begin
      if (link.sync_mode) begin
         // either pin may fall last; select-last is honoured though discouraged
         start_cond = !link.start_strobe_n && !link.chip_select_n && (sc_q || cs_q);
      end else begin
         start_cond = !link.start_strobe_n && sc_q;
      end
   end

   // sample coding: offset binary level, top bit flipped for bipolar range
   always_comb begin
      if (link.offset_range_pin) begin
         code = {~sample_level_i[11], sample_level_i[10:0]};
      end else begin
         code = sample_level_i;
      end
   end

   // conversion sequencer; starts during a conversion are ignored
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_q <= sacr_pkg::D_PWRUP;
         cnt_q <= 16'h0000;
      end else if (ce_i) begin
         case (state_q)
            sacr_pkg::D_PWRUP: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'(PWRUP_CYC - 1)) begin
                  state_q <= sacr_pkg::D_IDLE;
                  cnt_q <= 16'h0000;
               end
            end
            sacr_pkg::D_IDLE: begin
               cnt_q <= 16'h0000;
               if (start_cond) begin
                  state_q <= sacr_pkg::D_HOLD;
               end
            end
            sacr_pkg::D_HOLD: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'(HOLD_CYC - 1)) begin
                  state_q <= sacr_pkg::D_TRACK;
               end
            end
            sacr_pkg::D_TRACK: begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == 16'(CONV_CYC - 1)) begin
                  state_q <= sacr_pkg::D_IDLE;
               end
            end
            default: begin
               state_q <= sacr_pkg::D_PWRUP;
               cnt_q <= 16'h0000;
            end
         endcase
      end
   end

   // sample taken at the start edge, result published at completion
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         held_q <= 12'h000;
         result_q <= 12'h000;
      end else if (ce_i) begin
         if (state_q == sacr_pkg::D_IDLE && start_cond) begin
            held_q <= code;
         end
         if (state_q == sacr_pkg::D_TRACK && cnt_q == 16'(CONV_CYC - 1)) begin
            result_q <= held_q;
         end
      end
   end

   assign converting_o = (state_q == sacr_pkg::D_HOLD) || (state_q == sacr_pkg::D_TRACK);
   assign track_o = (state_q != sacr_pkg::D_HOLD);

   // done pin: open drain when async, three-state driver when sync
   always_comb begin
      if (link.sync_mode) begin
         link.done_oe = !link.chip_select_n && !link.done_flag_enable_n;
         link.done_out = !converting_o;
      end else begin
         link.done_oe = !link.done_flag_enable_n && converting_o;
         link.done_out = 1'b0;
      end
   end

   // byte formatting; line 1 picks right justify, line 0 low picks high byte
   always_comb begin
      if (link.result_bus[1]) begin
         if (!link.result_bus[0]) begin
            byte_sel = {{4{link.offset_range_pin & result_q[11]}}, result_q[11:8]};
         end else begin
            byte_sel = result_q[7:0];
         end
      end else begin
         if (!link.result_bus[0]) begin
            byte_sel = result_q[11:4];
         end else begin
            byte_sel = {result_q[3:0], 4'h0};
         end
      end
   end

   // registered bus drive; one cycle from select and read-enable to data
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         bus_q <= 12'h000;
         bus_oe_q <= 12'h000;
      end else if (ce_i) begin
         if (link.wide_mode) begin
            bus_q <= result_q;
         end else begin
            bus_q <= {byte_sel, 4'h0};
         end
         if (!link.chip_select_n && !link.read_enable_n) begin
            bus_oe_q <= link.wide_mode ? 12'hfff : 12'hff0;
         end else begin
            bus_oe_q <= 12'h000;
         end
      end
   end

   assign link.dev_bus_out = bus_q;
   assign link.dev_bus_oe = bus_oe_q;
endmodule

/* File: hdl/sacr_host.sv */
// host end: register-controlled start and readout sequencer on the bus side
`timescale 1ns/1ps
module sacr_host #(
   parameter int PULSE_CYC = sacr_pkg::START_PULSE_MIN_CYC,
   parameter int SETUP_CYC = sacr_pkg::SELECT_TO_START_SETUP_CYC,
   parameter int RD_SETUP_CYC = sacr_pkg::SELECT_TO_READ_SETUP_CYC,
   parameter int RECOVER_CYC = sacr_pkg::READ_TO_START_RECOVERY_CYC,
   parameter int REPEAT_CYC = sacr_pkg::START_REPEAT_INTERVAL_CYC,
   parameter int ACCESS_CYC = sacr_pkg::READ_ACCESS_CYC
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   sacr_link_if.host link,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic channel_advance_o
);
   sacr_pkg::sacr_host_state_e state_q;
   logic [15:0] cnt_q;
   logic [15:0] rep_q;
   logic [3:0] ctrl_q;
   logic pend_q;
   logic valid_q;
   logic rd_ack_q;
   logic [31:0] rdata_q;
   logic [7:0] hi_q;
   logic [11:0] result_q;
   logic done_q;
   logic chan_q;
   logic start_wr;
   logic rd_done;
   logic cnt_end;
   logic in_read;

   assign start_wr = avs_write_i && avs_address_i == sacr_pkg::REG_CMD && avs_byteenable_i[0]
                     && avs_writedata_i[sacr_pkg::CMD_START_BIT];
   // a start is held off while one is already queued or running
   assign avs_waitrequest_o = !ce_i || (avs_read_i && !rd_ack_q)
                              || (start_wr && (pend_q || state_q != sacr_pkg::H_IDLE));
   assign rd_done = avs_read_i && rd_ack_q && ce_i;
   assign cnt_end = (cnt_q == 16'h0000);
   assign in_read = state_q == sacr_pkg::H_RDSETUP || state_q == sacr_pkg::H_RDHI
                    || state_q == sacr_pkg::H_RDLO;

   // control register and start queue
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ctrl_q <= sacr_pkg::CTRL_RESET;
         pend_q <= 1'b0;
      end else if (ce_i) begin
         if (avs_write_i && avs_address_i == sacr_pkg::REG_CTRL && avs_byteenable_i[0]) begin
            ctrl_q <= avs_writedata_i[3:0];
         end
         if (start_wr && !avs_waitrequest_o) begin
            pend_q <= 1'b1;
         end else if (state_q == sacr_pkg::H_SETUP) begin
            pend_q <= 1'b0;
         end
      end
   end

   // reads take one wait cycle; unmapped offsets read zero
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rd_ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else if (ce_i) begin
         rd_ack_q <= avs_read_i && !rd_ack_q;
         case (avs_address_i)
            sacr_pkg::REG_CTRL: rdata_q <= {28'h0000000, ctrl_q};
            sacr_pkg::REG_STATUS: rdata_q <= {29'h00000000, valid_q, link.done_pin,
                                             pend_q || state_q != sacr_pkg::H_IDLE};
            sacr_pkg::REG_RESULT: rdata_q <= {20'h00000, result_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata_o = rdata_q;

   // result-valid flag: a new result wins over a clearing read
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         valid_q <= 1'b0;
      end else if (ce_i) begin
         if (state_q == sacr_pkg::H_RECOVER && cnt_end) begin
            valid_q <= 1'b1;
         end else if (rd_done && avs_address_i == sacr_pkg::REG_RESULT) begin
            valid_q <= 1'b0;
         end
      end
   end

   // strobe spacing counter, restarted at each strobe fall
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         rep_q <= 16'h0000;
      end else if (ce_i) begin
         if (state_q == sacr_pkg::H_SETUP && cnt_end) begin
            rep_q <= 16'(REPEAT_CYC - 1);
         end else if (rep_q != 16'h0000) begin
            rep_q <= rep_q - 16'h0001;
         end
      end
   end

   // channel may advance as soon as the done pin falls
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         done_q <= 1'b1;
         chan_q <= 1'b0;
      end else if (ce_i) begin
         done_q <= link.done_pin;
         // done falls during the strobe, so the strobe state must be watched too
         chan_q <= done_q && !link.done_pin
                   && (state_q == sacr_pkg::H_STROBE || state_q == sacr_pkg::H_WAIT);
      end
   end
   assign channel_advance_o = chan_q;

   // start and readout sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_q <= sacr_pkg::H_IDLE;
         cnt_q <= 16'h0000;
         hi_q <= 8'h00;
         result_q <= 12'h000;
      end else if (ce_i) begin
         if (!cnt_end) begin
            cnt_q <= cnt_q - 16'h0001;
         end
         case (state_q)
            sacr_pkg::H_IDLE: begin
               if (pend_q && rep_q == 16'h0000) begin
                  state_q <= sacr_pkg::H_SETUP;
                  cnt_q <= 16'(SETUP_CYC - 1);
               end
            end
            sacr_pkg::H_SETUP: begin
               if (cnt_end) begin
                  state_q <= sacr_pkg::H_STROBE;
                  cnt_q <= 16'(PULSE_CYC - 1);
               end
            end
            sacr_pkg::H_STROBE: begin
               if (cnt_end) begin
                  state_q <= sacr_pkg::H_WAIT;
               end
            end
            sacr_pkg::H_WAIT: begin
               if (link.done_pin && done_q && !chan_q) begin
                  state_q <= sacr_pkg::H_RDSETUP;
                  cnt_q <= 16'(RD_SETUP_CYC - 1);
               end
            end
            sacr_pkg::H_RDSETUP: begin
               if (cnt_end) begin
                  state_q <= sacr_pkg::H_RDHI;
                  cnt_q <= 16'(ACCESS_CYC - 1);
               end
            end
            sacr_pkg::H_RDHI: begin
               if (cnt_end) begin
                  if (ctrl_q[sacr_pkg::CTRL_WIDE_BIT]) begin
                     result_q <= link.result_bus;
                     state_q <= sacr_pkg::H_RECOVER;
                     cnt_q <= 16'(RECOVER_CYC - 1);
                  end else begin
                     hi_q <= link.result_bus[11:4];
                     state_q <= sacr_pkg::H_RDLO;
                     cnt_q <= 16'(ACCESS_CYC - 1);
                  end
               end
            end
            sacr_pkg::H_RDLO: begin
               if (cnt_end) begin
                  if (ctrl_q[sacr_pkg::CTRL_RIGHT_BIT]) begin
                     result_q <= {hi_q[3:0], link.result_bus[11:4]};
                  end else begin
                     result_q <= {hi_q, link.result_bus[11:8]};
                  end
                  state_q <= sacr_pkg::H_RECOVER;
                  cnt_q <= 16'(RECOVER_CYC - 1);
               end
            end
            sacr_pkg::H_RECOVER: begin
               if (cnt_end) begin
                  state_q <= sacr_pkg::H_IDLE;
               end
            end
            default: begin
               state_q <= sacr_pkg::H_IDLE;
            end
         endcase
      end
   end

   // pin drive; select leads the strobe in sync mode and always leads read
   assign link.chip_select_n = !(in_read || (ctrl_q[sacr_pkg::CTRL_SYNC_BIT] &&
      (state_q == sacr_pkg::H_SETUP || state_q == sacr_pkg::H_STROBE
       || state_q == sacr_pkg::H_WAIT)));
   assign link.start_strobe_n = (state_q != sacr_pkg::H_STROBE);
   assign link.read_enable_n = !(state_q == sacr_pkg::H_RDHI || state_q == sacr_pkg::H_RDLO);
   assign link.done_flag_enable_n = !(state_q == sacr_pkg::H_STROBE
                                      || state_q == sacr_pkg::H_WAIT);
   assign link.sync_mode = ctrl_q[sacr_pkg::CTRL_SYNC_BIT];
   assign link.wide_mode = ctrl_q[sacr_pkg::CTRL_WIDE_BIT];
   assign link.offset_range_pin = ctrl_q[sacr_pkg::CTRL_BIPOLAR_BIT];
   // byte mode: host drives justify and high-byte select (low picks high byte)
   assign link.host_bus_oe = (in_read && !ctrl_q[sacr_pkg::CTRL_WIDE_BIT]) ? 2'h3 : 2'h0;
   assign link.host_bus_out = {ctrl_q[sacr_pkg::CTRL_RIGHT_BIT],
                               state_q == sacr_pkg::H_RDLO};
endmodule

/* File: verification/sacr_link_monitor.sv */
// assertion checker watching the link between the host and converter ends
`timescale 1ns/1ps
module sacr_link_monitor #(
   parameter int PWRUP_CYC = 20,
   parameter int CONV_CYC = 40
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic start_strobe_n,
   input wire logic chip_select_n,
   input wire logic read_enable_n,
   input wire logic done_flag_enable_n,
   input wire logic sync_mode,
   input wire logic wide_mode,
   input wire logic done_out,
   input wire logic done_oe,
   input wire logic done_pin,
   input wire logic [11:0] dev_bus_oe
);
   logic [15:0] up_q;
   logic [15:0] low_q;
   // cycles since reset; starts inside the power-up window are ignored, so they are not judged
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) up_q <= 16'h0000;
      else if (up_q <= 16'(PWRUP_CYC)) up_q <= up_q + 16'h0001;
   end
   // length of the current low stretch of the done pin
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || done_pin) low_q <= 16'h0000;
      else low_q <= low_q + 16'h0001;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_start_sync;
      sync_mode && !start_strobe_n && !chip_select_n && done_pin && up_q > 16'(PWRUP_CYC)
         && ($past(start_strobe_n) || $past(chip_select_n)) |=> !done_pin;
   endproperty
   a_start_sync: assert property (p_start_sync) else $error("sync start not seen");
   property p_start_async;
      !sync_mode && $fell(start_strobe_n) && done_pin && up_q > 16'(PWRUP_CYC) |=> !done_pin;
   endproperty
   a_start_async: assert property (p_start_async) else $error("async start missed");
   property p_conv_len;
      $rose(done_pin) |-> low_q >= 16'(CONV_CYC - 2) && low_q <= 16'(CONV_CYC + 1);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
   property p_done_bounded;
      !done_pin |-> low_q <= 16'(CONV_CYC + 1);
   endproperty
   a_done_bounded: assert property (p_done_bounded) else $error("done stuck low");
   property p_bus_gate;
      (|dev_bus_oe) |-> $past(!chip_select_n && !read_enable_n);
   endproperty
   a_bus_gate: assert property (p_bus_gate) else $error("bus driven unselected");
   property p_wide_all;
      wide_mode && $past(wide_mode) && $past(!chip_select_n && !read_enable_n)
         |-> dev_bus_oe == 12'hfff;
   endproperty
   a_wide_all: assert property (p_wide_all) else $error("wide read not full");
   property p_byte_upper;
      !wide_mode && $past(!wide_mode) && $past(!chip_select_n && !read_enable_n)
         |-> dev_bus_oe == 12'hff0;
   endproperty
   a_byte_upper: assert property (p_byte_upper) else $error("byte lanes wrong");
   property p_byte_inputs;
      !wide_mode && $past(!wide_mode) |-> dev_bus_oe[1:0] == 2'b00;
   endproperty
   a_byte_inputs: assert property (p_byte_inputs) else $error("format lines driven");
   property p_od_async;
      !sync_mode && done_oe |-> !done_out && !done_flag_enable_n;
   endproperty
   a_od_async: assert property (p_od_async) else $error("done not open drain");
   property p_drive_sync;
      sync_mode |-> done_oe == (!chip_select_n && !done_flag_enable_n);
   endproperty
   a_drive_sync: assert property (p_drive_sync) else $error("done drive wrong");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
module tb_top;
   localparam int PWRUP = 20;
   localparam int CONV = 40;
   localparam int HOLD = 10;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [11:0] level = 12'h000;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic [31:0] rdata_q;
   logic wait_req;
   logic adv;
   logic track;
   logic conv_busy;
   int hold_cnt = 0;
   logic [7:0] hi_seen;
   logic [7:0] lo_seen;
   int adv_cnt = 0;
   int bad_count = 0;
   int comparisons = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   sacr_link_if sacr_link_if_inst ();
   sacr_device #(.PWRUP_CYC(PWRUP), .HOLD_CYC(HOLD), .CONV_CYC(CONV)) sacr_device_inst (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .link(sacr_link_if_inst),
      .sample_level_i(level), .track_o(track), .converting_o(conv_busy));
   sacr_host #(.REPEAT_CYC(50)) sacr_host_inst (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .link(sacr_link_if_inst),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
      .channel_advance_o(adv));
   sacr_link_monitor #(.PWRUP_CYC(PWRUP), .CONV_CYC(CONV)) sacr_link_monitor_inst (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .start_strobe_n(sacr_link_if_inst.start_strobe_n),
      .chip_select_n(sacr_link_if_inst.chip_select_n),
      .read_enable_n(sacr_link_if_inst.read_enable_n),
      .done_flag_enable_n(sacr_link_if_inst.done_flag_enable_n),
      .sync_mode(sacr_link_if_inst.sync_mode), .wide_mode(sacr_link_if_inst.wide_mode),
      .done_out(sacr_link_if_inst.done_out), .done_oe(sacr_link_if_inst.done_oe),
      .done_pin(sacr_link_if_inst.done_pin), .dev_bus_oe(sacr_link_if_inst.dev_bus_oe));
   // the last sample of each byte phase wins, since the device drive lags the select by an edge
   always @(posedge sys_clk_i) begin
      if (!sacr_link_if_inst.read_enable_n && sacr_link_if_inst.dev_bus_oe[11]) begin
         if (sacr_link_if_inst.result_bus[0]) lo_seen <= sacr_link_if_inst.result_bus[11:4];
         else hi_seen <= sacr_link_if_inst.result_bus[11:4];
      end
      if (adv) adv_cnt <= adv_cnt + 1;
      // sampler hold cycles, counted to judge the hold phase of each conversion
      if (conv_busy && !track) hold_cnt <= hold_cnt + 1;
   end
   task automatic wrap_up;
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus cycle; the request stands until the edge that samples waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      for (n = 0; n < 200; n++) begin
         @(posedge sys_clk_i);
         if (wait_req === 1'b0) begin
            rdata_q = rdata;
            break;
         end
      end
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 200) begin
         bad_count++;
         $display("BAD t=%0t timeout addr=%h data=%h", $time, a, d);
         wrap_up();
      end
   endtask
   // one conversion in the given format, then the result, the bytes in byte mode only, and the side effects
   task automatic conv(input logic [3:0] ctrl, input logic [11:0] lvl);
      logic [11:0] code;
      logic [7:0] hi;
      logic [7:0] lo;
      int n;
      int h;
      code = ctrl[2] ? {~lvl[11], lvl[10:0]} : lvl;
      hi = ctrl[3] ? {{4{ctrl[2] & code[11]}}, code[11:8]} : code[11:4];
      lo = ctrl[3] ? code[7:0] : {code[3:0], 4'h0};
      n = adv_cnt;
      h = hold_cnt;
      level <= lvl;
      bus(1'b1, sacr_pkg::REG_CTRL, {28'h0000000, ctrl});
      bus(1'b1, sacr_pkg::REG_CMD, 32'h00000001);
      for (int k = 0; k < 100; k++) begin
         bus(1'b0, sacr_pkg::REG_STATUS, 32'h00000000);
         if (rdata_q[2] === 1'b1) break;
      end
      // a result that never becomes valid ends the run
      if (rdata_q[2] !== 1'b1) begin
         bad_count++;
         $display("BAD t=%0t timeout status=%h exp=%h", $time, rdata_q, 32'h00000004);
         wrap_up();
      end
      bus(1'b0, sacr_pkg::REG_RESULT, 32'h00000000);
      check({20'h00000, rdata_q[11:0]}, {20'h00000, code});
      if (!ctrl[1]) check({16'h0000, hi_seen, lo_seen}, {16'h0000, hi, lo});
      check(32'(adv_cnt - n), 32'h00000001);
      check(32'(hold_cnt - h), 32'(HOLD));
      bus(1'b0, sacr_pkg::REG_STATUS, 32'h00000000);
      check({31'h0, rdata_q[2]}, 32'h00000000);
   endtask
   initial begin
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      bus(1'b0, sacr_pkg::REG_CTRL, 32'h00000000);
      check(rdata_q, {28'h0000000, sacr_pkg::CTRL_RESET});
      bus(1'b0, 4'h1, 32'h00000000);
      check(rdata_q, 32'h00000000);
      be <= 4'h0;
      bus(1'b1, sacr_pkg::REG_CTRL, 32'h0000000f);
      be <= 4'hf;
      bus(1'b1, 4'h1, 32'hffffffff);
      bus(1'b0, sacr_pkg::REG_CTRL, 32'h00000000);
      check(rdata_q, {28'h0000000, sacr_pkg::CTRL_RESET});
      repeat (PWRUP) @(posedge sys_clk_i);
      conv(4'h3, 12'h800);
      conv(4'hf, 12'h000);
      conv(4'h8, 12'h0ab);
      conv(4'hc, 12'h123);
      conv(4'h4, 12'habc);
      conv(4'h1, 12'hfff);
      conv(4'h6, 12'h7ff);
      conv(4'hd, 12'h345);
      wrap_up();
   end
endmodule
